// ===== rtcsup_top.sv
// Supervisor, power-fail, battery, oscillator-stop and century logic behind APB
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// Notes on behaviour
// RL1 - Two reset inputs act as power cycle
// RL2 - Low pulses under 100 ns ignored
// RL3 - Reset output held for recovery time
// RL4 - Fail outputs low while sense below reference
// RL5 - Backup: comparators off, fail outputs low
// RL6 - Supply return: fail outputs forced high
// RL7 - Drive select: 1 open-drain, 0 push-pull
// RL8 - Century bits count binary on rollover
// RL9 - Leap century only when century zero
// RL10 - No source enabled: pin follows level bit
// RL11 - Backup enable keeps level drive in backup
// RL12 - Battery test at power-up and daily
// RL13 - Weak flag held until test passes
// RL14 - Battery tests only on main supply
// RL15 - Deselect-length bit selects blocking time
// RL16 - Recovery time chosen by length, halt bits
// RL17 - Writes refused during recovery time
// RL18 - Fixed eight-byte serial number, read only
// RL19 - Oscillator stop sets fail flag
// RL20 - Fail flag with enable drives interrupt
// RL21 - Fail flag stays until written zero
// RL22 - Stop detect in backup, pin needs enable
// RL23 - Halt bit stops oscillator when one
// RL24 - Reset held while input low, then timed
module rtcsup_top #(
  parameter int unsigned          REC_DEF    = rtcsup_pkg::REC_DEF_CYC,
  parameter int unsigned          REC_HALT   = rtcsup_pkg::REC_HALT_CYC,
  parameter int unsigned          REC_SHORT  = rtcsup_pkg::REC_SHORT_CYC,
  parameter longint unsigned      BATT_PER   = rtcsup_pkg::BATT_PERIOD_CYC,
  parameter logic [63:0]          SERIAL_NUM = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  input  wire logic [3:0]                 pstrb,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       ext_reset_in_a,
  input  wire logic                       ext_reset_in_b,
  input  wire logic                       supply_sense_in_a,
  input  wire logic                       supply_sense_in_b,
  input  wire logic                       main_supply_ok,
  input  wire logic                       battery_ok,
  input  wire logic                       osc_running,
  input  wire logic                       other_irq_request,
  output rtcsup_pkg::rtcsup_pin_type      supply_fail_out_a,
  output rtcsup_pkg::rtcsup_pin_type      supply_fail_out_b,
  output rtcsup_pkg::rtcsup_pin_type      irq_out,
  output logic                            reset_out_n,
  output logic                            osc_enable,
  output logic                            write_blocked
);

  localparam int unsigned GW = $clog2(rtcsup_pkg::GLITCH_CYC + 1);

  rtcsup_pkg::rtcsup_state_type state;
  rtcsup_pkg::rtcsup_state_type next_state;
  rtcsup_pkg::rtcsup_ctrl_type  ctrl;
  logic [31:0] rec_cnt;
  logic [GW-1:0] low_cnt_a;
  logic [GW-1:0] low_cnt_b;
  logic        held_a;
  logic        held_b;
  logic [63:0] batt_cnt;
  logic        battery_weak_flag;
  logic        oscillator_fail_flag;
  logic [1:0]  century;
  logic        batt_test_pending;
  logic [31:0] rd_mux;
  logic        slverr_mux;

  // Qualified low level on each reset input; shorter pulses never reach the reset logic
  assign held_a = (low_cnt_a >= GW'(rtcsup_pkg::GLITCH_CYC)); // RL2
  assign held_b = (low_cnt_b >= GW'(rtcsup_pkg::GLITCH_CYC)); // RL2

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_a <= '0;
      low_cnt_b <= '0;
    end else begin
      low_cnt_a <= ext_reset_in_a ? '0 : (held_a ? low_cnt_a : low_cnt_a + 1'b1);
      low_cnt_b <= ext_reset_in_b ? '0 : (held_b ? low_cnt_b : low_cnt_b + 1'b1);
    end
  end

  wire logic ext_hold   = held_a | held_b; // RL1 RL24
  wire logic inputs_low = !ext_reset_in_a || !ext_reset_in_b;

  // Recovery length selection
  wire logic [31:0] rec_len = ctrl.deselect_length_bit ? REC_SHORT :
                              (ctrl.oscillator_halt_bit ? REC_HALT : REC_DEF); // RL15 RL16
  wire logic rec_done = (rec_cnt >= rec_len - 32'd1);

  always_comb begin
    next_state = state;
    case (state)
      rtcsup_pkg::RTCSUP_ST_BACKUP:  if (main_supply_ok) next_state = rtcsup_pkg::RTCSUP_ST_RECOVER;
      rtcsup_pkg::RTCSUP_ST_HOLD:    if (!inputs_low) next_state = rtcsup_pkg::RTCSUP_ST_RECOVER; // RL24
      rtcsup_pkg::RTCSUP_ST_RECOVER: if (rec_done) next_state = rtcsup_pkg::RTCSUP_ST_RUN; // RL3
      rtcsup_pkg::RTCSUP_ST_RUN:     next_state = rtcsup_pkg::RTCSUP_ST_RUN;
      default:                       next_state = rtcsup_pkg::RTCSUP_ST_BACKUP;
    endcase
    if (!main_supply_ok) next_state = rtcsup_pkg::RTCSUP_ST_BACKUP; // RL5
    else if (ext_hold) next_state = rtcsup_pkg::RTCSUP_ST_HOLD; // RL1
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= rtcsup_pkg::RTCSUP_ST_BACKUP;
      rec_cnt <= '0;
    end else begin
      state   <= next_state;
      rec_cnt <= (state == rtcsup_pkg::RTCSUP_ST_RECOVER && next_state == state) ?
                 rec_cnt + 32'd1 : 32'd0; // RL3
    end
  end

  wire logic in_backup  = (state == rtcsup_pkg::RTCSUP_ST_BACKUP);
  wire logic in_run     = (state == rtcsup_pkg::RTCSUP_ST_RUN);
  wire logic reset_evt  = !in_run && !in_backup;
  // Writes blocked during deselect and its continuation
  assign write_blocked = !in_run; // RL17

  // APB decode
  wire logic apb_acc  = psel && penable;
  wire logic hit_ctrl = (paddr == rtcsup_pkg::ADDR_CTRL);
  wire logic hit_flag = (paddr == rtcsup_pkg::ADDR_FLAGS);
  wire logic hit_cent = (paddr == rtcsup_pkg::ADDR_CENTURY);
  wire logic hit_slo  = (paddr == rtcsup_pkg::ADDR_SER_LO);
  wire logic hit_shi  = (paddr == rtcsup_pkg::ADDR_SER_HI);
  wire logic hit_evt  = (paddr == rtcsup_pkg::ADDR_EVENT);
  wire logic hit_any  = hit_ctrl | hit_flag | hit_cent | hit_slo | hit_shi | hit_evt;
  wire logic wr_ok    = apb_acc && pwrite && pstrb[0] && in_run; // RL17
  wire logic wr_ctrl  = wr_ok && hit_ctrl;
  wire logic wr_flag  = wr_ok && hit_flag;
  wire logic wr_cent  = wr_ok && hit_cent;
  wire logic wr_evt   = wr_ok && hit_evt;
  // Serial number is read only; writes to it raise an error
  wire logic bad_wr   = pwrite && (hit_slo || hit_shi || !in_run); // RL18

  assign pready = 1'b1;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) rd_mux = {24'h00_0000, ctrl};
    if (hit_flag) rd_mux = {27'h0, battery_weak_flag, 1'b0, oscillator_fail_flag, 2'b00};
    // Bit 2 marks a leap century; only the zero count qualifies
    if (hit_cent) rd_mux = {29'h0, (century == 2'b00), century}; // RL9
    if (hit_slo)  rd_mux = SERIAL_NUM[31:0]; // RL18
    if (hit_shi)  rd_mux = SERIAL_NUM[63:32]; // RL18
    slverr_mux = !hit_any || bad_wr;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      pslverr <= psel && !penable && slverr_mux;
    end
  end

  // Interrupt enables and back-up enable clear on any reset event; level and
  // length, halt and drive bits survive, as they would across a power cycle
  wire logic [7:0] ctrl_w = pwdata[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= rtcsup_pkg::CTRL_RESET;
    end else if (reset_evt) begin
      ctrl.osc_stop_irq_enable <= 1'b0; // RL1
      ctrl.alarm_irq_enable    <= 1'b0;
      ctrl.tamper_irq_enable   <= 1'b0;
      ctrl.backup_alarm_enable <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl <= ctrl_w; // RL15 RL7
    end
  end

  assign osc_enable = !ctrl.oscillator_halt_bit; // RL23

  // Oscillator fail flag: stop event wins over a software clear
  wire logic osc_stop = !osc_running || ctrl.oscillator_halt_bit; // RL19 RL22
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_fail_flag <= rtcsup_pkg::OSC_FAIL_RESET; // RL19
    end else if (osc_stop) begin
      oscillator_fail_flag <= 1'b1; // RL19 RL22
    end else if (wr_flag && !pwdata[rtcsup_pkg::FLAG_OSC_FAIL]) begin
      oscillator_fail_flag <= 1'b0; // RL21
    end
  end

  // Battery test at power-up and every period; main supply only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batt_cnt          <= 64'h0;
      batt_test_pending <= 1'b1;
      battery_weak_flag <= 1'b0;
    end else if (!main_supply_ok) begin
      batt_cnt          <= 64'h0; // RL14
      batt_test_pending <= 1'b1; // RL12
    end else if (batt_test_pending) begin
      battery_weak_flag <= !battery_ok; // RL12 RL13
      batt_test_pending <= 1'b0;
      batt_cnt          <= 64'h0;
    end else if (batt_cnt >= BATT_PER - 64'd1) begin
      batt_test_pending <= 1'b1; // RL12
      batt_cnt          <= 64'h0;
    end else begin
      batt_cnt <= batt_cnt + 64'd1;
    end
  end

  // Century count on each year rollover event written to the event register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      century <= 2'b00;
    end else if (wr_evt && pwdata[rtcsup_pkg::EVT_YEAR_WRAP]) begin
      century <= century + 2'b01; // RL8
    end else if (wr_cent) begin
      century <= pwdata[1:0];
    end
  end

  // Fail outputs: comparators only in run; forced high in recovery
  logic fail_a_lvl;
  logic fail_b_lvl;
  always_comb begin
    if (in_backup) begin
      fail_a_lvl = 1'b0; // RL5
      fail_b_lvl = 1'b0;
    end else if (!in_run) begin
      fail_a_lvl = 1'b1; // RL6
      fail_b_lvl = 1'b1;
    end else begin
      fail_a_lvl = supply_sense_in_a; // RL4
      fail_b_lvl = supply_sense_in_b; // RL4
    end
  end

  // Open-drain only pulls low; push-pull always drives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_fail_out_a <= '0;
      supply_fail_out_b <= '0;
    end else begin
      supply_fail_out_a.o  <= fail_a_lvl;
      supply_fail_out_a.oe <= !ctrl.fail_drive_select || !fail_a_lvl; // RL7
      supply_fail_out_b.o  <= fail_b_lvl;
      supply_fail_out_b.oe <= !ctrl.fail_drive_select || !fail_b_lvl; // RL7
    end
  end

  // Interrupt pin, open drain, low means asserted
  wire logic any_src = ctrl.tamper_irq_enable || ctrl.osc_stop_irq_enable ||
                       ctrl.alarm_irq_enable || other_irq_request;
  wire logic osc_irq = ctrl.osc_stop_irq_enable && oscillator_fail_flag &&
                       !reset_evt && (!in_backup || ctrl.backup_alarm_enable); // RL20 RL22
  wire logic lvl_low = !any_src && !ctrl.out_level &&
                       (!in_backup || ctrl.backup_alarm_enable); // RL10 RL11
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out     <= '0;
      reset_out_n <= 1'b0;
    end else begin
      irq_out.o   <= 1'b0;
      irq_out.oe  <= osc_irq || lvl_low; // RL20 RL10
      reset_out_n <= in_run; // RL3 RL1
    end
  end

endmodule : rtcsup_top

// ===== rtcsup_pkg.sv
// Package for the supervisor and status logic: constants, offsets and carrier types
package rtcsup_pkg;

  localparam int unsigned CLK_MHZ = 250;

  // Times in their own units, counts derived from the clock
  localparam int unsigned GLITCH_NS        = 100;
  localparam int unsigned GLITCH_CYC       = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REC_DEF_US       = 96000;
  localparam int unsigned REC_DEF_CYC      = REC_DEF_US * CLK_MHZ;
  localparam int unsigned REC_HALT_US      = 40000;
  localparam int unsigned REC_HALT_CYC     = REC_HALT_US * CLK_MHZ;
  localparam int unsigned REC_SHORT_US     = 50;
  localparam int unsigned REC_SHORT_CYC    = REC_SHORT_US * CLK_MHZ;
  localparam int unsigned BATT_PERIOD_S    = 86400;
  localparam longint unsigned BATT_PERIOD_CYC = longint'(BATT_PERIOD_S) * 64'd250000000;
  localparam int unsigned OSC_SETTLE_S     = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_FLAGS   = 8'h04;
  localparam logic [7:0] ADDR_CENTURY = 8'h08;
  localparam logic [7:0] ADDR_SER_LO  = 8'h0c;
  localparam logic [7:0] ADDR_SER_HI  = 8'h10;
  localparam logic [7:0] ADDR_EVENT   = 8'h14;

  // Control register field positions
  localparam int unsigned CTRL_OUT_LEVEL = 7;
  localparam int unsigned CTRL_DESEL_LEN = 6;
  localparam int unsigned CTRL_HALT      = 5;
  localparam int unsigned CTRL_FAIL_DRV  = 4;
  localparam int unsigned CTRL_OSC_IE    = 3;
  localparam int unsigned CTRL_ALARM_IE  = 2;
  localparam int unsigned CTRL_TAMP_IE   = 1;
  localparam int unsigned CTRL_BKP_AE    = 0;
  // Flag register field positions
  localparam int unsigned FLAG_BATT_WEAK = 4;
  localparam int unsigned FLAG_OSC_FAIL  = 2;
  localparam int unsigned FLAG_WD_ACTIVE = 1;
  // Event register write bits
  localparam int unsigned EVT_YEAR_WRAP  = 0;

  // Reset values
  localparam logic [7:0] CTRL_RESET  = 8'h90;
  localparam logic       OSC_FAIL_RESET = 1'b1;

  typedef enum logic [1:0] {
    RTCSUP_ST_BACKUP,
    RTCSUP_ST_HOLD,
    RTCSUP_ST_RECOVER,
    RTCSUP_ST_RUN
  } rtcsup_state_type;

  typedef struct packed {
    logic out_level;
    logic deselect_length_bit;
    logic oscillator_halt_bit;
    logic fail_drive_select;
    logic osc_stop_irq_enable;
    logic alarm_irq_enable;
    logic tamper_irq_enable;
    logic backup_alarm_enable;
  } rtcsup_ctrl_type;

  typedef struct packed {
    logic o;
    logic oe;
  } rtcsup_pin_type;

endpackage : rtcsup_pkg

// ===== rtcsup_properties.sv
// Port-level checks for the supervisor block
`timescale 1ns/1ns
module rtcsup_properties (
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [7:0]                 paddr,
  input wire logic                       pslverr,
  input wire logic                       ext_reset_in_a,
  input wire logic                       ext_reset_in_b,
  input wire logic                       supply_sense_in_a,
  input wire logic                       main_supply_ok,
  input wire rtcsup_pkg::rtcsup_pin_type supply_fail_out_a,
  input wire rtcsup_pkg::rtcsup_pin_type supply_fail_out_b,
  input wire logic                       reset_out_n,
  input wire logic                       write_blocked
);
  logic [7:0] low_cnt;
  wire        acc = psel && penable;
  // Saturates so a long hold never wraps back into the glitch range
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) low_cnt <= 8'h00;
    else if (ext_reset_in_a) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  blocked_write_a: assert property (acc && pwrite && write_blocked |-> pslverr)
    else $error("write accepted while blocked");
  serial_ro_a: assert property (acc && pwrite && (paddr == 8'h0c || paddr == 8'h10) |-> pslverr)
    else $error("serial word written");
  backup_low_a: assert property (!main_supply_ok [*3] |-> !supply_fail_out_a.o && !supply_fail_out_b.o)
    else $error("fail output high in backup");
  recover_high_a: assert property ((main_supply_ok && write_blocked && ext_reset_in_a && ext_reset_in_b) [*3]
    |-> supply_fail_out_a.o && supply_fail_out_b.o) else $error("fail output not forced high");
  fail_track_a: assert property ((!write_blocked && main_supply_ok) [*2]
    |-> supply_fail_out_a.o == $past(supply_sense_in_a)) else $error("fail output not tracking");
  held_reset_a: assert property (low_cnt >= 8'h28 |-> !reset_out_n)
    else $error("reset output high while input held low");
  glitch_ignore_a: assert property (reset_out_n && ext_reset_in_b && main_supply_ok && !write_blocked
    && low_cnt < 8'h10 |=> !write_blocked) else $error("short pulse caused reset");
  run_unreset_a: assert property (!write_blocked [*2] |-> reset_out_n)
    else $error("reset output low while running");
endmodule : rtcsup_properties
bind rtcsup_top rtcsup_properties props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pslverr(pslverr),
  .ext_reset_in_a(ext_reset_in_a), .ext_reset_in_b(ext_reset_in_b),
  .supply_sense_in_a(supply_sense_in_a), .main_supply_ok(main_supply_ok),
  .supply_fail_out_a(supply_fail_out_a), .supply_fail_out_b(supply_fail_out_b),
  .reset_out_n(reset_out_n), .write_blocked(write_blocked));

// ===== rtcsup_host_model.sv
// Oscillator and pull-up loads on the host and supply side
`timescale 1ns/1ns
module rtcsup_host_model (
  input wire logic                       osc_enable,
  input wire logic                       main_supply_ok,
  input wire logic                       battery_ok,
  input wire logic                       osc_kill,
  input wire rtcsup_pkg::rtcsup_pin_type fail_a,
  input wire rtcsup_pkg::rtcsup_pin_type fail_b,
  output logic                           osc_running,
  output logic                           fail_pin_a,
  output logic                           fail_pin_b
);
  // Oscillation needs power from either source and no halt
  assign osc_running = osc_enable && (main_supply_ok || battery_ok) && !osc_kill;
  // Released lines rise through the pull-ups
  assign fail_pin_a = fail_a.oe ? fail_a.o : 1'b1;
  assign fail_pin_b = fail_b.oe ? fail_b.o : 1'b1;
endmodule : rtcsup_host_model

// ===== rtcsup_top_test.sv
// Self-checking bench for the supervisor block
`timescale 1ns/1ns
module rtcsup_top_test;
  localparam int unsigned RD = 60, RH = 40, RS = 20, BP = 50;
  localparam logic [63:0] SN = 64'h5a5a_1234_c3c3_8765; // Arbitrary value
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, rst_a = 1'b1, rst_b = 1'b1, sns_a = 1'b1, sns_b = 1'b1;
  logic        main_ok = 1'b1, batt_ok = 1'b1, kill = 1'b0, oirq = 1'b0;
  logic        osc_run, osc_en, rst_n_out, blocked, pin_a, pin_b;
  rtcsup_pkg::rtcsup_pin_type fo_a, fo_b, irq;
  int          miscompares = 0, comparisons = 0, cyc = 0, n;
  logic [15:0] lfsr = 16'h4b61;
  logic [7:0]  cv[3] = '{8'h88, 8'hc0, 8'ha0};
  int          rv[3] = '{RD, RS, RH};
  rtcsup_top #(.REC_DEF(RD), .REC_HALT(RH), .REC_SHORT(RS), .BATT_PER(BP), .SERIAL_NUM(SN)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_reset_in_a(rst_a), .ext_reset_in_b(rst_b),
    .supply_sense_in_a(sns_a), .supply_sense_in_b(sns_b), .main_supply_ok(main_ok),
    .battery_ok(batt_ok), .osc_running(osc_run), .other_irq_request(oirq),
    .supply_fail_out_a(fo_a), .supply_fail_out_b(fo_b), .irq_out(irq),
    .reset_out_n(rst_n_out), .osc_enable(osc_en), .write_blocked(blocked));
  rtcsup_host_model host (.osc_enable(osc_en), .main_supply_ok(main_ok), .battery_ok(batt_ok),
    .osc_kill(kill), .fail_a(fo_a), .fail_b(fo_b), .osc_running(osc_run),
    .fail_pin_a(pin_a), .fail_pin_b(pin_b));
  always #2 pclk = ~pclk;
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand
  task automatic close_out();
    $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Setup, then access held until pready; settles two edges after
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(nm, e, rd & m);
  endtask : rdchk
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (blocked !== 1'b0) begin @(posedge pclk); n++; end
    chk("power-up recovery", 32'h1, {31'h0, n >= RD && n <= RD + 4});
    rdchk("ctrl", 8'h00, 32'hff, 32'h90);
    rdchk("flags", 8'h04, 32'h14, 32'h04);
    rdchk("serial lo", 8'h0c, 32'hffffffff, SN[31:0]);
    rdchk("serial hi", 8'h10, 32'hffffffff, SN[63:32]);
    apb(1'b1, 8'h10, 32'h0, 1'b1);
    apb(1'b0, 8'h20, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'h00, 1'b0);
    chk("level low", 32'h1, {31'h0, irq.oe});
    oirq <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("level masked", 32'h0, {31'h0, irq.oe});
    oirq <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      lfsr = next_rand(lfsr);
      sns_a <= lfsr[0];
      sns_b <= lfsr[1];
      apb(1'b1, 8'h00, {24'h0, 3'h4, lfsr[2], 4'h0}, 1'b0);
      chk("fail pin a", {31'h0, lfsr[0]}, {31'h0, pin_a});
      chk("fail b enable", {31'h0, !lfsr[2] || !lfsr[1]}, {31'h0, fo_b.oe});
    end
    chk("level high", 32'h0, {31'h0, irq.oe});
    apb(1'b1, 8'h04, 32'h0, 1'b0);
    rdchk("osc clear", 8'h04, 32'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h88, 1'b0);
    kill <= 1'b1;
    repeat (4) @(posedge pclk);
    kill <= 1'b0;
    rdchk("osc stop", 8'h04, 32'h04, 32'h04);
    chk("osc irq", 32'h1, {31'h0, irq.oe});
    apb(1'b1, 8'h04, 32'h0, 1'b0);
    chk("osc irq off", 32'h0, {31'h0, irq.oe});
    apb(1'b1, 8'h00, 32'ha0, 1'b0);
    chk("halt", 32'h0, {31'h0, osc_en});
    rdchk("halt flag", 8'h04, 32'h04, 32'h04);
    apb(1'b1, 8'h08, 32'h3, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h14, 32'h1, 1'b0);
      rdchk("century", 8'h08, 32'h7, {29'h0, i == 0, i[1:0]});
    end
    batt_ok <= 1'b0;
    repeat (BP + 10) @(posedge pclk);
    rdchk("battery weak", 8'h04, 32'h10, 32'h10);
    batt_ok <= 1'b1;
    repeat (BP + 10) @(posedge pclk);
    rdchk("battery good", 8'h04, 32'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h01, 1'b0);
    main_ok <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("backup level", 32'h1, {31'h0, irq.oe});
    chk("backup fail", 32'h0, {31'h0, fo_a.o});
    apb(1'b1, 8'h00, 32'h80, 1'b1);
    main_ok <= 1'b1;
    sns_a <= 1'b0;
    repeat (5) @(posedge pclk);
    chk("forced high", 32'h1, {31'h0, fo_a.o});
    while (blocked !== 1'b0) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk("tracking", 32'h0, {31'h0, fo_a.o});
    // Short pulse stays under the filter width
    rst_a <= 1'b0;
    repeat (10) @(posedge pclk);
    rst_a <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("glitch", 32'h1, {31'h0, rst_n_out});
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h00, {24'h0, cv[i]}, 1'b0);
      if (i[0]) rst_b <= 1'b0;
      else rst_a <= 1'b0;
      repeat (40) @(posedge pclk);
      chk("held", 32'h0, {31'h0, rst_n_out});
      chk("reset irq", 32'h0, {31'h0, irq.oe});
      rst_a <= 1'b1;
      rst_b <= 1'b1;
      n = 0;
      while (rst_n_out !== 1'b1) begin @(posedge pclk); n++; end
      chk("recovery", 32'h1, {31'h0, n >= rv[i] && n <= rv[i] + 4});
      rdchk("enables", 8'h00, 32'h0f, 32'h0);
    end
    close_out();
  end
endmodule : rtcsup_top_test
